// [core/limit_status_pkg.sv]
// Register map, field layout, reset values and timing for limit_status_alert_logic.
// Assumes an SMBus slave outside that turns bus cycles into one-cycle strobes.
package limit_status_pkg;

  // Register offsets
  localparam logic [7:0] CONFIG1_ADDR        = 8'h01;
  localparam logic [7:0] MASK1_ADDR          = 8'h08;
  localparam logic [7:0] MASK2_ADDR          = 8'h09;
  localparam logic [7:0] MASK3_ADDR          = 8'h0a;
  localparam logic [7:0] LOCAL_HIGH_ADDR     = 8'h0b;
  localparam logic [7:0] LOCAL_LOW_ADDR      = 8'h0c;
  localparam logic [7:0] LOCAL_THERMAL_ADDR  = 8'h0d;
  localparam logic [7:0] REMOTE_HIGH_ADDR    = 8'h0e;
  localparam logic [7:0] REMOTE_LOW_ADDR     = 8'h0f;
  localparam logic [7:0] REMOTE_THERMAL_ADDR = 8'h10;
  localparam logic [7:0] TIMER_LIMIT_ADDR    = 8'h19;
  localparam logic [7:0] LOCAL_VALUE_ADDR    = 8'h41;
  localparam logic [7:0] REMOTE_VALUE_ADDR   = 8'h43;
  localparam logic [7:0] TEMP_STATUS_ADDR    = 8'h4f;
  localparam logic [7:0] THERMAL_PIN_STATUS_ADDR   = 8'h50;
  localparam logic [7:0] FAN_STATUS_ADDR     = 8'h51;

  // Reset values
  localparam logic [7:0] HIGH_LIMIT_RST    = 8'h8b;
  localparam logic [7:0] LOW_LIMIT_RST     = 8'h54;
  localparam logic [7:0] THERMAL_LIMIT_RST = 8'h95;
  localparam logic [7:0] TIMER_LIMIT_RST   = 8'hff;
  localparam logic [7:0] CONFIG1_RST       = 8'h01;
  localparam logic [7:0] MASK_RST          = 8'h00;
  localparam logic [7:0] VALUE_RST         = 8'h00;

  // Field positions
  localparam int RUN_BIT         = 0;
  localparam int LOCAL_HIGH_BIT  = 7;
  localparam int LOCAL_LOW_BIT   = 6;
  localparam int REMOTE_HIGH_BIT = 5;
  localparam int REMOTE_LOW_BIT  = 4;
  localparam int DIODE_ERR_BIT   = 3;
  localparam int LOCAL_THERMAL_PIN_BIT = 7;
  localparam int REMOTE_THERMAL_PIN_BIT = 6;
  localparam int TIMER_HIT_BIT   = 4;
  localparam int THERMAL_PIN_ASSERT_BIT = 3;
  localparam int PIN_ACTIVE_BIT  = 2;
  localparam int FAN_STALL_BIT   = 7;
  localparam int FAN_ALARM_BIT   = 6;
  localparam int ALERT_LOW_BIT   = 0;

  // Implemented status bits; the rest read as zero, except the alert bit of fan status
  localparam logic [7:0] TEMP_STATUS_USED  = 8'hf8;
  localparam logic [7:0] THERMAL_PIN_STATUS_USED = 8'hdc;
  localparam logic [7:0] FAN_STATUS_USED   = 8'hc0;

  // Conversion timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int LOCAL_CONV_MS  = 11;
  localparam int REMOTE_CONV_MS = 32;
  localparam int LOCAL_CONV_CYC  = LOCAL_CONV_MS * (CLK_HZ / 1000);
  localparam int REMOTE_CONV_CYC = REMOTE_CONV_MS * (CLK_HZ / 1000);

  // Round-robin sequencer, Gray along idle -> local -> remote
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_LOCAL  = 2'b01,
    SEQ_REMOTE = 2'b11
  } seq_state_t;

  // One register access from the bus slave
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Live conditions from the front end and fan logic
  typedef struct packed {
    logic [7:0] adc_value;
    logic       diode_fault;
    logic       thermal_timer_hit;
    logic       thermal_asserted;
    logic       thermal_pin;
    logic       fan_stall;
    logic       fan_alarm;
  } sense_t;

endpackage

// [core/limit_status_alert_logic.sv]
// Limit comparison, sticky status, masks and both alert outputs.
// Assumes a bus slave delivering one-cycle register strobes and a
// front end whose conversion result is valid at the end of each slot.
//
// Function
// - High violation when value at or above limit
// - Low violation only when value below limit
// - Per-channel high, low, thermal limits with resets
// - Round robin, status updated after each comparison
// - Run bit starts or stops monitoring
// - Store each result in its value register
// - Local slot 11 ms, remote 32 ms
// - Restart round robin after cycle elapses
// - Fan conditions tracked independent of temperature
// - Status one means out of limit
// - Sticky until in limit, then read/ARA
// - Status bit shows bus alert driven low
// - Comparator alert follows unmasked live conditions; pin active counts even when masked
// - Bus alert latched, needs software to release
// - Masks gate alerts, not status bits; the pin-active mask gates only the bus alert
// - Temperature status field layout
// - Thermal status field layout
// - Pin-active bit clears on read if inactive
// - Fan stall and alarm status bits
// - Bus alert low until in limit and cleared
// - Mask bit one suppresses its source; comparator ignores the pin-active mask bit
`timescale 1ns/100ps
`default_nettype none

module limit_status_alert_logic #(
  parameter int LOCAL_CONV_CYCLES  = limit_status_pkg::LOCAL_CONV_CYC,
  parameter int REMOTE_CONV_CYCLES = limit_status_pkg::REMOTE_CONV_CYC
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // Register access
  input  wire limit_status_pkg::reg_req_t reg_req,
  output logic [7:0]                      reg_rdata,
  input  wire logic                       ara_done,
  // Front end and fan conditions
  input  wire limit_status_pkg::sense_t   sense,
  output logic                            adc_start,
  output logic                            adc_remote,
  // Alert pins
  output logic                            smb_alert_n,
  output logic                            comp_alert_n
);

  localparam int CNT_W = 23;

  // Elaboration check: the slot counter must hold both slot lengths
  if (LOCAL_CONV_CYCLES < 1 || REMOTE_CONV_CYCLES < 1 ||
      LOCAL_CONV_CYCLES >= (1 << CNT_W) ||
      REMOTE_CONV_CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
    $error("conversion cycle counts out of range");
  end

  localparam logic [CNT_W-1:0] LOCAL_LAST  = CNT_W'(LOCAL_CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] REMOTE_LAST = CNT_W'(REMOTE_CONV_CYCLES - 1);

  // Configuration and limit registers
  logic [7:0] config1_r, config1_nxt;
  logic [7:0] mask1_r, mask1_nxt;
  logic [7:0] mask2_r, mask2_nxt;
  logic [7:0] mask3_r, mask3_nxt;
  logic [7:0] local_high_limit_r, local_high_limit_nxt;
  logic [7:0] local_low_limit_r, local_low_limit_nxt;
  logic [7:0] local_thermal_limit_r, local_thermal_limit_nxt;
  logic [7:0] remote_high_limit_r, remote_high_limit_nxt;
  logic [7:0] remote_low_limit_r, remote_low_limit_nxt;
  logic [7:0] remote_thermal_limit_r, remote_thermal_limit_nxt;
  logic [7:0] thermal_timer_limit_r, thermal_timer_limit_nxt;

  // Sequencer, values, live conditions, sticky status
  limit_status_pkg::seq_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             start_r, start_nxt;
  logic [7:0]       local_value_r, local_value_nxt;
  logic [7:0]       remote_value_r, remote_value_nxt;
  logic [7:0]       cond1_r, cond1_nxt;
  logic [7:0]       cond2_r, cond2_nxt;
  logic [7:0]       cond3_r, cond3_nxt;
  logic [7:0]       temp_status_r, temp_status_nxt;
  logic [7:0]       thermal_status_r, thermal_status_nxt;
  logic [7:0]       fan_alert_status_r, fan_alert_status_nxt;
  logic             smb_alert_n_r, smb_alert_n_nxt;
  logic             comp_alert_n_r, comp_alert_n_nxt;
  logic [7:0]       rdata_r, rdata_nxt;

  logic run;
  logic slot_end;
  assign run      = config1_r[limit_status_pkg::RUN_BIT];
  assign slot_end = (state_r == limit_status_pkg::SEQ_LOCAL &&
                     cnt_r == LOCAL_LAST) ||
                    (state_r == limit_status_pkg::SEQ_REMOTE &&
                     cnt_r == REMOTE_LAST);

  // Register writes; writes to read-only or unmapped offsets are dropped
  always_comb begin
    config1_nxt              = config1_r;
    mask1_nxt                = mask1_r;
    mask2_nxt                = mask2_r;
    mask3_nxt                = mask3_r;
    local_high_limit_nxt     = local_high_limit_r;
    local_low_limit_nxt      = local_low_limit_r;
    local_thermal_limit_nxt  = local_thermal_limit_r;
    remote_high_limit_nxt    = remote_high_limit_r;
    remote_low_limit_nxt     = remote_low_limit_r;
    remote_thermal_limit_nxt = remote_thermal_limit_r;
    thermal_timer_limit_nxt  = thermal_timer_limit_r;
    if (reg_req.wr) begin
      case (reg_req.addr)
        limit_status_pkg::CONFIG1_ADDR:        config1_nxt = reg_req.wdata;
        limit_status_pkg::MASK1_ADDR:          mask1_nxt = reg_req.wdata;
        limit_status_pkg::MASK2_ADDR:          mask2_nxt = reg_req.wdata;
        limit_status_pkg::MASK3_ADDR:          mask3_nxt = reg_req.wdata;
        limit_status_pkg::LOCAL_HIGH_ADDR:     local_high_limit_nxt = reg_req.wdata;
        limit_status_pkg::LOCAL_LOW_ADDR:      local_low_limit_nxt = reg_req.wdata;
        limit_status_pkg::LOCAL_THERMAL_ADDR:  local_thermal_limit_nxt = reg_req.wdata;
        limit_status_pkg::REMOTE_HIGH_ADDR:    remote_high_limit_nxt = reg_req.wdata;
        limit_status_pkg::REMOTE_LOW_ADDR:     remote_low_limit_nxt = reg_req.wdata;
        limit_status_pkg::REMOTE_THERMAL_ADDR: remote_thermal_limit_nxt = reg_req.wdata;
        limit_status_pkg::TIMER_LIMIT_ADDR:    thermal_timer_limit_nxt = reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Configuration and limit flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      config1_r              <= limit_status_pkg::CONFIG1_RST;
      mask1_r                <= limit_status_pkg::MASK_RST;
      mask2_r                <= limit_status_pkg::MASK_RST;
      mask3_r                <= limit_status_pkg::MASK_RST;
      local_high_limit_r     <= limit_status_pkg::HIGH_LIMIT_RST;
      local_low_limit_r      <= limit_status_pkg::LOW_LIMIT_RST;
      local_thermal_limit_r  <= limit_status_pkg::THERMAL_LIMIT_RST;
      remote_high_limit_r    <= limit_status_pkg::HIGH_LIMIT_RST;
      remote_low_limit_r     <= limit_status_pkg::LOW_LIMIT_RST;
      remote_thermal_limit_r <= limit_status_pkg::THERMAL_LIMIT_RST;
      thermal_timer_limit_r  <= limit_status_pkg::TIMER_LIMIT_RST;
    end else begin
      config1_r              <= config1_nxt;
      mask1_r                <= mask1_nxt;
      mask2_r                <= mask2_nxt;
      mask3_r                <= mask3_nxt;
      local_high_limit_r     <= local_high_limit_nxt;
      local_low_limit_r      <= local_low_limit_nxt;
      local_thermal_limit_r  <= local_thermal_limit_nxt;
      remote_high_limit_r    <= remote_high_limit_nxt;
      remote_low_limit_r     <= remote_low_limit_nxt;
      remote_thermal_limit_r <= remote_thermal_limit_nxt;
      thermal_timer_limit_r  <= thermal_timer_limit_nxt;
    end
  end

  // Round robin: local slot, remote slot, back to local
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + CNT_W'(1);
    start_nxt = 1'b0;
    case (state_r)
      limit_status_pkg::SEQ_IDLE: begin
        cnt_nxt = '0;
        if (run) begin
          state_nxt = limit_status_pkg::SEQ_LOCAL;
          start_nxt = 1'b1;
        end
      end
      limit_status_pkg::SEQ_LOCAL: begin
        if (cnt_r == LOCAL_LAST) begin
          cnt_nxt   = '0;
          state_nxt = limit_status_pkg::SEQ_REMOTE;
          start_nxt = 1'b1;
        end
      end
      limit_status_pkg::SEQ_REMOTE: begin
        if (cnt_r == REMOTE_LAST) begin
          cnt_nxt   = '0;
          state_nxt = limit_status_pkg::SEQ_LOCAL;
          start_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = limit_status_pkg::SEQ_IDLE;
        cnt_nxt   = '0;
      end
    endcase
    // Stop takes effect at once; a slot in flight is abandoned
    if (!run) begin
      state_nxt = limit_status_pkg::SEQ_IDLE;
      cnt_nxt   = '0;
      start_nxt = 1'b0;
    end
  end

  // Result capture and comparison at the end of each slot
  always_comb begin
    local_value_nxt  = local_value_r;
    remote_value_nxt = remote_value_r;
    cond1_nxt        = cond1_r;
    cond2_nxt        = cond2_r;
    cond3_nxt        = '0;
    if (slot_end && state_r == limit_status_pkg::SEQ_LOCAL) begin
      local_value_nxt = sense.adc_value;
      cond1_nxt[limit_status_pkg::LOCAL_HIGH_BIT] =
        sense.adc_value >= local_high_limit_r;
      cond1_nxt[limit_status_pkg::LOCAL_LOW_BIT] =
        sense.adc_value < local_low_limit_r;
      cond2_nxt[limit_status_pkg::LOCAL_THERMAL_PIN_BIT] =
        sense.adc_value >= local_thermal_limit_r;
    end
    if (slot_end && state_r == limit_status_pkg::SEQ_REMOTE) begin
      remote_value_nxt = sense.adc_value;
      cond1_nxt[limit_status_pkg::REMOTE_HIGH_BIT] =
        sense.adc_value >= remote_high_limit_r;
      cond1_nxt[limit_status_pkg::REMOTE_LOW_BIT] =
        sense.adc_value < remote_low_limit_r;
      cond1_nxt[limit_status_pkg::DIODE_ERR_BIT] = sense.diode_fault;
      cond2_nxt[limit_status_pkg::REMOTE_THERMAL_PIN_BIT] =
        sense.adc_value >= remote_thermal_limit_r;
    end
    // Thermal and fan conditions are live, not tied to slots
    cond2_nxt[limit_status_pkg::TIMER_HIT_BIT]    = sense.thermal_timer_hit;
    cond2_nxt[limit_status_pkg::THERMAL_PIN_ASSERT_BIT] = sense.thermal_asserted;
    cond2_nxt[limit_status_pkg::PIN_ACTIVE_BIT]   = sense.thermal_pin;
    cond3_nxt[limit_status_pkg::FAN_STALL_BIT]    = sense.fan_stall;
    cond3_nxt[limit_status_pkg::FAN_ALARM_BIT]    = sense.fan_alarm;
  end

  // Sticky status: set every cycle the condition holds, so set beats clear
  logic rd_temp, rd_thermal_pin, rd_fan;
  logic [7:0] unmasked1, unmasked2, unmasked3;
  logic smb_src, comp_src;
  assign rd_temp  = reg_req.rd &&
                    reg_req.addr == limit_status_pkg::TEMP_STATUS_ADDR;
  assign rd_thermal_pin = reg_req.rd &&
                    reg_req.addr == limit_status_pkg::THERMAL_PIN_STATUS_ADDR;
  assign rd_fan   = reg_req.rd &&
                    reg_req.addr == limit_status_pkg::FAN_STATUS_ADDR;

  always_comb begin
    temp_status_nxt      = temp_status_r;
    thermal_status_nxt   = thermal_status_r;
    fan_alert_status_nxt = fan_alert_status_r;
    if (rd_temp || ara_done) begin
      temp_status_nxt = temp_status_r & cond1_r;
    end
    if (rd_thermal_pin || ara_done) begin
      thermal_status_nxt = thermal_status_r & cond2_r;
    end
    if (rd_fan || ara_done) begin
      fan_alert_status_nxt = fan_alert_status_r & cond3_r;
    end
    temp_status_nxt = (temp_status_nxt | cond1_r) &
                      limit_status_pkg::TEMP_STATUS_USED;
    thermal_status_nxt = (thermal_status_nxt | cond2_r) &
                         limit_status_pkg::THERMAL_PIN_STATUS_USED;
    fan_alert_status_nxt = (fan_alert_status_nxt | cond3_r) &
                           limit_status_pkg::FAN_STATUS_USED;
  end

  // Alert sources; masks never touch the status bits themselves
  assign unmasked1 = temp_status_r & ~mask1_r;
  assign unmasked2 = thermal_status_r & ~mask2_r;
  assign unmasked3 = fan_alert_status_r & ~mask3_r;
  assign smb_src   = |{unmasked1, unmasked2, unmasked3};
  // Comparator ignores the pin-active mask, so that bit always counts
  assign comp_src  = |{cond1_r & ~mask1_r,
                       cond2_r & ~(mask2_r &
                         ~(8'h01 << limit_status_pkg::PIN_ACTIVE_BIT)),
                       cond3_r & ~mask3_r};

  always_comb begin
    smb_alert_n_nxt  = ~smb_src;
    comp_alert_n_nxt = ~comp_src;
  end

  // Read data, registered; status reads show the value before clearing
  always_comb begin
    case (reg_req.addr)
      limit_status_pkg::CONFIG1_ADDR:        rdata_nxt = config1_r;
      limit_status_pkg::MASK1_ADDR:          rdata_nxt = mask1_r;
      limit_status_pkg::MASK2_ADDR:          rdata_nxt = mask2_r;
      limit_status_pkg::MASK3_ADDR:          rdata_nxt = mask3_r;
      limit_status_pkg::LOCAL_HIGH_ADDR:     rdata_nxt = local_high_limit_r;
      limit_status_pkg::LOCAL_LOW_ADDR:      rdata_nxt = local_low_limit_r;
      limit_status_pkg::LOCAL_THERMAL_ADDR:  rdata_nxt = local_thermal_limit_r;
      limit_status_pkg::REMOTE_HIGH_ADDR:    rdata_nxt = remote_high_limit_r;
      limit_status_pkg::REMOTE_LOW_ADDR:     rdata_nxt = remote_low_limit_r;
      limit_status_pkg::REMOTE_THERMAL_ADDR: rdata_nxt = remote_thermal_limit_r;
      limit_status_pkg::TIMER_LIMIT_ADDR:    rdata_nxt = thermal_timer_limit_r;
      limit_status_pkg::LOCAL_VALUE_ADDR:    rdata_nxt = local_value_r;
      limit_status_pkg::REMOTE_VALUE_ADDR:   rdata_nxt = remote_value_r;
      limit_status_pkg::TEMP_STATUS_ADDR:    rdata_nxt = temp_status_r;
      limit_status_pkg::THERMAL_PIN_STATUS_ADDR:   rdata_nxt = thermal_status_r;
      limit_status_pkg::FAN_STATUS_ADDR: begin
        rdata_nxt = fan_alert_status_r;
        rdata_nxt[limit_status_pkg::ALERT_LOW_BIT] = ~smb_alert_n_r;
      end
      default:                               rdata_nxt = 8'h00;
    endcase
    if (!reg_req.rd) begin
      rdata_nxt = rdata_r;
    end
  end

  // Sequencer, status and output flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r            <= limit_status_pkg::SEQ_IDLE;
      cnt_r              <= '0;
      start_r            <= 1'b0;
      local_value_r      <= limit_status_pkg::VALUE_RST;
      remote_value_r     <= limit_status_pkg::VALUE_RST;
      cond1_r            <= 8'h00;
      cond2_r            <= 8'h00;
      cond3_r            <= 8'h00;
      temp_status_r      <= 8'h00;
      thermal_status_r   <= 8'h00;
      fan_alert_status_r <= 8'h00;
      smb_alert_n_r      <= 1'b1;
      comp_alert_n_r     <= 1'b1;
      rdata_r            <= 8'h00;
    end else begin
      state_r            <= state_nxt;
      cnt_r              <= cnt_nxt;
      start_r            <= start_nxt;
      local_value_r      <= local_value_nxt;
      remote_value_r     <= remote_value_nxt;
      cond1_r            <= cond1_nxt;
      cond2_r            <= cond2_nxt;
      cond3_r            <= cond3_nxt;
      temp_status_r      <= temp_status_nxt;
      thermal_status_r   <= thermal_status_nxt;
      fan_alert_status_r <= fan_alert_status_nxt;
      smb_alert_n_r      <= smb_alert_n_nxt;
      comp_alert_n_r     <= comp_alert_n_nxt;
      rdata_r            <= rdata_nxt;
    end
  end

  // Outputs from flops; adc_remote is decoded from the state flops
  assign reg_rdata    = rdata_r;
  assign adc_start    = start_r;
  assign adc_remote   = (state_r == limit_status_pkg::SEQ_REMOTE);
  assign smb_alert_n  = smb_alert_n_r;
  assign comp_alert_n = comp_alert_n_r;

endmodule

`default_nettype wire

// [verif/status_checker.sv]
// Port-level assertions for limit_status_alert_logic.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module status_checker (
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       reset,
  // Register access
  input wire limit_status_pkg::reg_req_t reg_req,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       ara_done,
  // Front end and alerts
  input wire limit_status_pkg::sense_t   sense,
  input wire logic                       adc_start,
  input wire logic                       adc_remote,
  input wire logic                       smb_alert_n,
  input wire logic                       comp_alert_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Any software action that may let the bus alert go
  wire logic sw_evt = reg_req.rd | reg_req.wr | ara_done;

  property p_start_pulse;
    adc_start |=> !adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("conversion start held past one cycle");

  property p_release;
    $rose(smb_alert_n) |-> $past(sw_evt) || $past(sw_evt, 2)
      || $past(sw_evt, 3);
  endproperty
  a_release: assert property (p_release)
    else $error("bus alert released with no read or response");

  property p_alert_bit;
    reg_req.rd && reg_req.addr == limit_status_pkg::FAN_STATUS_ADDR
      |=> reg_rdata[0] == !$past(smb_alert_n);
  endproperty
  a_alert_bit: assert property (p_alert_bit)
    else $error("alert bit disagrees with bus alert pin");

  property p_temp_rsvd;
    reg_req.rd && reg_req.addr == limit_status_pkg::TEMP_STATUS_ADDR
      |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_temp_rsvd: assert property (p_temp_rsvd)
    else $error("reserved temperature status bits set");

  property p_thermal_pin_rsvd;
    reg_req.rd && reg_req.addr == limit_status_pkg::THERMAL_PIN_STATUS_ADDR
      |=> reg_rdata[5] == 1'b0 && reg_rdata[1:0] == 2'h0;
  endproperty
  a_thermal_pin_rsvd: assert property (p_thermal_pin_rsvd)
    else $error("reserved thermal status bits set");

  // Pin activity is never masked from the comparator output
  property p_pin_comp;
    sense.thermal_pin [*2] |=> !comp_alert_n;
  endproperty
  a_pin_comp: assert property (p_pin_comp)
    else $error("comparator alert high with pin active");

  property p_pin_status;
    sense.thermal_pin [*2] ##1 (reg_req.rd
      && reg_req.addr == limit_status_pkg::THERMAL_PIN_STATUS_ADDR)
      |=> reg_rdata[limit_status_pkg::PIN_ACTIVE_BIT];
  endproperty
  a_pin_status: assert property (p_pin_status)
    else $error("pin active bit missing");

  property p_unmapped;
    reg_req.rd && reg_req.addr == 8'h20 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
endmodule

bind limit_status_alert_logic status_checker status_checker_inst (
  .mclk(mclk), .reset(reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .ara_done(ara_done), .sense(sense),
  .adc_start(adc_start), .adc_remote(adc_remote),
  .smb_alert_n(smb_alert_n), .comp_alert_n(comp_alert_n));

`default_nettype wire

// [verif/front_end_model.sv]
// Stand-in for the converter front end.
// Assumes the block samples adc_value on a slot's last cycle.
`timescale 1ns/100ps
`default_nettype none

module front_end_model (
  // Slot control from the block
  input  wire logic       adc_remote,
  // Readings chosen by the bench
  input  wire logic [7:0] local_temp,
  input  wire logic [7:0] remote_temp,
  // Result to the block
  output logic [7:0]      adc_value
);
  // Mux only; slot timing stays the block's business
  assign adc_value = adc_remote ? remote_temp : local_temp;
endmodule

`default_nettype wire

// [verif/limit_status_alert_logic_bench.sv]
// Self-checking bench for limit_status_alert_logic.
// Assumes short slot lengths and the front-end model beside it.
`timescale 1ns/100ps
`default_nettype none

module limit_status_alert_logic_bench;
  localparam int LOC = 5;
  localparam int REM = 8;
  logic                       mclk = 1'b0;
  logic                       reset = 1'b1;
  logic                       ara_done = 1'b0;
  logic [5:0]                 flags = 6'h00;
  logic [7:0]                 loc_t = 8'h60;
  logic [7:0]                 rem_t = 8'h60;
  logic [7:0]                 rdata;
  logic [7:0]                 fe_value;
  logic                       adc_start;
  logic                       adc_remote;
  logic                       smb_alert_n;
  logic                       comp_alert_n;
  logic                       r;
  limit_status_pkg::reg_req_t req = '0;
  limit_status_pkg::sense_t   sense;
  int                         miscompares = 0;
  int                         total_checks = 0;
  int                         gap;
  logic [15:0]                rst_tab [10] = '{16'h0b8b, 16'h0c54,
    16'h0d95, 16'h0e8b, 16'h0f54, 16'h1095, 16'h19ff, 16'h0101,
    16'h0800, 16'h4f00};

  // Flags: diode, timer, asserted, pin, stall, alarm
  assign sense = {fe_value, flags};
  always #5 mclk = ~mclk;

  limit_status_alert_logic #(
    .LOCAL_CONV_CYCLES (LOC),
    .REMOTE_CONV_CYCLES(REM)
  ) limit_status_alert_logic_inst (
    .mclk(mclk), .reset(reset), .reg_req(req), .reg_rdata(rdata),
    .ara_done(ara_done), .sense(sense), .adc_start(adc_start),
    .adc_remote(adc_remote), .smb_alert_n(smb_alert_n),
    .comp_alert_n(comp_alert_n));
  front_end_model front_end_model_inst (
    .adc_remote(adc_remote), .local_temp(loc_t),
    .remote_temp(rem_t), .adc_value(fe_value));

  task automatic chk(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One strobe cycle; a gap cycle always follows
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge mclk);
    #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    #1 req = '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, exp);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), exp, rdata);
  endtask

  // Long enough for a full local and remote slot after a change
  task automatic settle;
    repeat (3 * (LOC + REM)) @(posedge mclk);
    #1;
  endtask

  task automatic next_start(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (adc_start !== 1'b1 && n < 100);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    foreach (rst_tab[i]) rd_chk(rst_tab[i][15:8], rst_tab[i][7:0]);
    $display("end reset values");
    // Exact limits: thermal trips, low does not; local high trips above its limit
    loc_t = 8'h95;
    rem_t = 8'h54;
    settle();
    rd_chk(8'h4f, 8'h80);
    rd_chk(8'h50, 8'h80);
    rd_chk(8'h41, 8'h95);
    rd_chk(8'h43, 8'h54);
    chk("comp", 8'h00, {7'h0, comp_alert_n});
    rd_chk(8'h51, 8'h01);
    loc_t = 8'h60;
    settle();
    chk("comp", 8'h01, {7'h0, comp_alert_n});
    chk("smb", 8'h00, {7'h0, smb_alert_n});
    rd_chk(8'h4f, 8'h80);
    rd_chk(8'h50, 8'h80);
    rd_chk(8'h4f, 8'h00);
    rd_chk(8'h51, 8'h00);
    $display("end limits and sticky");
    // Masked sources still set status, then a response cycle clears
    bus(1'b1, 8'h08, 8'hf8);
    loc_t = 8'h8c;
    rem_t = 8'h53;
    settle();
    chk("smb", 8'h01, {7'h0, smb_alert_n});
    chk("comp", 8'h01, {7'h0, comp_alert_n});
    loc_t = 8'h60;
    rem_t = 8'h60;
    settle();
    bus(1'b1, 8'h08, 8'h00);
    repeat (3) @(posedge mclk);
    #1 chk("smb", 8'h00, {7'h0, smb_alert_n});
    ara_done = 1'b1;
    @(posedge mclk);
    #1 ara_done = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("smb", 8'h01, {7'h0, smb_alert_n});
    rd_chk(8'h4f, 8'h00);
    $display("end masks and response");
    // Live conditions, and the pin bit held while the pin is active
    flags = 6'h3f;
    settle();
    rd_chk(8'h4f, 8'h08);
    rd_chk(8'h50, 8'h1c);
    rd_chk(8'h51, 8'hc1);
    flags = 6'h04;
    rd_chk(8'h50, 8'h1c);
    rd_chk(8'h50, 8'h04);
    flags = 6'h00;
    settle();
    rd_chk(8'h50, 8'h04);
    rd_chk(8'h50, 8'h00);
    rd_chk(8'h4f, 8'h08);
    rd_chk(8'h4f, 8'h00);
    rd_chk(8'h51, 8'hc1);
    rd_chk(8'h51, 8'h00);
    $display("end live conditions");
    // Standby: no conversions, fan tracking carries on
    bus(1'b1, 8'h01, 8'h00);
    repeat (2) @(posedge mclk);
    #1 flags = 6'h02;
    gap = 0;
    repeat (40) begin
      @(posedge mclk);
      #1 gap += adc_start;
    end
    chk("starts in standby", 8'h00, gap[7:0]);
    flags = 6'h00;
    rd_chk(8'h51, 8'h81);
    rd_chk(8'h51, 8'h00);
    // Pin and fan masks: pin still drives the comparator
    bus(1'b1, 8'h09, 8'h1c);
    bus(1'b1, 8'h0a, 8'hc0);
    flags = 6'h06;
    settle();
    chk("smb", 8'h01, {7'h0, smb_alert_n});
    chk("comp", 8'h00, {7'h0, comp_alert_n});
    flags = 6'h00;
    settle();
    chk("comp", 8'h01, {7'h0, comp_alert_n});
    rd_chk(8'h50, 8'h04);
    rd_chk(8'h51, 8'h80);
    bus(1'b1, 8'h09, 8'h00);
    bus(1'b1, 8'h0a, 8'h00);
    bus(1'b1, 8'h01, 8'h01);
    next_start(gap);
    chk("restart", 8'h00, {7'h0, adc_remote});
    repeat (3) begin
      r = adc_remote;
      next_start(gap);
      chk("slot length", r ? 8'(REM) : 8'(LOC), gap[7:0]);
      chk("slot kind", {7'h0, !r}, {7'h0, adc_remote});
    end
    $display("end run control");
    // Read-only status and an unmapped place
    bus(1'b1, 8'h4f, 8'hff);
    rd_chk(8'h4f, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("end refused access");
    finish_test();
  end
endmodule

`default_nettype wire
